// File: ccc_cooling_control.sv
// Functional notes
// - A new demand first purges with the bypass valve open while inlet is above setpoint.
// - When inlet reaches setpoint, bypass closes, cooling valves open, cooling starts.
// - Chamber above maximum raises a demand automatically, purge then cooling.
// - Only sampleValid (low holds the last sample), lidOpen and the chamberMax and lidMax settings can suppress or shift the automatic demand.
// - In cooling, coil outlet below minimum closes and holds the cooling valves.
// - Valves reopen once coil outlet reaches minimum plus coil deadband.
// - Cooling ends, valves closed, when chamber reaches maximum minus chamber deadband.
// - After startup the alarm outputs assert and a cooling demand starts.
// - Mute key silences the buzzer for 30 minutes, then it sounds again if alarmed.
// - A setting disables the buzzer entirely.
// - Lid open shortens the interval between cycles via a lower start threshold.
// - Storage temperature is clamped to -50 C .. -150 C.
// - Inlet, chamber max, coil min and both deadbands are user settings.
// - Purge longer than the supply delay raises supply alarm and starts cooling.
`include "ccc_consts.svh"
module ccc_cooling_control #(
   parameter logic [`CCC_CNT_W-1:0] MUTE_CYC = `CCC_CNT_W'(`CCC_MUTE_CYC),
   parameter logic [`CCC_CNT_W-1:0] SUPPLY_CYC = `CCC_CNT_W'(`CCC_SUPPLY_CYC)
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic sampleValid,
   input wire ccc_pkg::ccc_temps_type temps,
   input wire ccc_pkg::ccc_settings_type settings,
   input wire logic lidOpen,
   input wire logic muteKey,
   input wire logic buzzerDisable,
   input wire logic otherAlarm,
   output logic bypassValve,
   output logic coolValves,
   output logic alarmOut,
   output logic buzzer,
   output logic supplyAlarm,
   output logic [2:0] phase
);
   // ==========================================
   // Sample hold and clamping
   ccc_pkg::ccc_temps_type smp_reg, smp_next;
   logic signed [11:0] chMax, startThr, stopThr, coilOpen;
   always_comb begin
      chMax = settings.chamberMax;
      if (chMax > `CCC_STORE_MAX) chMax = `CCC_STORE_MAX;
      if (chMax < `CCC_STORE_MIN) chMax = `CCC_STORE_MIN;
      startThr = (lidOpen && settings.lidMax < chMax) ? settings.lidMax : chMax;
      stopThr = 12'(chMax - settings.chamberBand);
      coilOpen = 12'(settings.coilMin + settings.coilBand);
      smp_next = sampleValid ? temps : smp_reg;
   end
   // ==========================================
   // Cycle state machine
   ccc_pkg::ccc_state_type st_reg, st_next;
   logic started_reg, started_next, supAl_reg, supAl_next;
   logic supStart, supStop, supRun, supExp;
   ccc_timer #(.COUNT(SUPPLY_CYC)) supplyTimer (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(supStart),
      .stop(supStop),
      .running(supRun),
      .expired(supExp)
   );
   always_comb begin
      st_next = st_reg;
      started_next = 1'b1;
      supAl_next = supAl_reg;
      supStart = 1'b0;
      supStop = 1'b0;
      case (st_reg)
         ccc_pkg::IDLE: begin
            if (!started_reg || (tick && smp_reg.chamber > startThr)) begin
               st_next = ccc_pkg::PURGE;
               supStart = 1'b1;
               supAl_next = 1'b0;
            end
         end
         ccc_pkg::PURGE: begin
            if (supExp) begin
               supAl_next = 1'b1;
               st_next = ccc_pkg::COOL;
            end else if (tick && smp_reg.inlet <= settings.inletSet) begin
               st_next = ccc_pkg::COOL;
               supStop = 1'b1;
            end
         end
         ccc_pkg::COOL: begin
            if (tick && smp_reg.chamber <= stopThr) begin
               st_next = ccc_pkg::IDLE;
            end else if (tick && smp_reg.coil < settings.coilMin) begin
               st_next = ccc_pkg::COILHOLD;
            end
         end
         ccc_pkg::COILHOLD: begin
            if (tick && smp_reg.chamber <= stopThr) begin
               st_next = ccc_pkg::IDLE;
            end else if (tick && smp_reg.coil >= coilOpen) begin
               st_next = ccc_pkg::COOL;
            end
         end
         default: st_next = ccc_pkg::IDLE;
      endcase
   end
   // ==========================================
   // Buzzer mute
   logic muteRun, muteStart, startedAlarm_reg, startedAlarm_next;
   ccc_timer #(.COUNT(MUTE_CYC)) muteTimer (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(muteStart),
      .stop(1'b0),
      .running(muteRun),
      .expired()
   );
   logic alarmAny;
   always_comb begin
      alarmAny = !started_reg || supAl_reg || otherAlarm || startedAlarm_reg;
      muteStart = muteKey && alarmAny;
   end
   always_comb begin
      startedAlarm_next = startedAlarm_reg;
      if (!started_reg) begin
         startedAlarm_next = 1'b1;
      end else if (st_reg != ccc_pkg::IDLE && st_next == ccc_pkg::IDLE) begin
         startedAlarm_next = 1'b0;
      end
   end
   // ==========================================
   // Registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_reg <= ccc_pkg::IDLE;
         started_reg <= 1'b0;
         supAl_reg <= 1'b0;
         startedAlarm_reg <= 1'b0;
         smp_reg <= '0;
      end else begin
         st_reg <= st_next;
         started_reg <= started_next;
         supAl_reg <= supAl_next;
         startedAlarm_reg <= startedAlarm_next;
         smp_reg <= smp_next;
      end
   end
   // ==========================================
   // Outputs
   always_comb begin
      bypassValve = st_reg == ccc_pkg::PURGE;
      coolValves = st_reg == ccc_pkg::COOL;
      alarmOut = alarmAny;
      buzzer = alarmAny && !muteRun && !buzzerDisable;
      supplyAlarm = supAl_reg;
      phase = 3'(st_reg);
   end
   // ==========================================
   // Assertions
   purge_bypass_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg == ccc_pkg::PURGE && !supExp && !(tick && smp_reg.inlet <= settings.inletSet))
      |=> bypassValve && !coolValves)
      else $error("bypass closed too early");
   purge_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg == ccc_pkg::PURGE && tick && smp_reg.inlet <= settings.inletSet)
      |=> coolValves && !bypassValve)
      else $error("purge did not hand over");
   demand_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg == ccc_pkg::IDLE && tick && smp_reg.chamber > startThr) |=> bypassValve)
      else $error("demand missed");
   coil_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg == ccc_pkg::COOL && tick && smp_reg.chamber > stopThr
      && smp_reg.coil < settings.coilMin) |=> !coolValves)
      else $error("coil cold not closed");
   coil_reopen_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg == ccc_pkg::COILHOLD && tick && smp_reg.chamber > stopThr
      && smp_reg.coil >= coilOpen) |=> coolValves)
      else $error("coil reopen missed");
   cycle_end_a: assert property (@(posedge clk) disable iff (sys_rst)
      (coolValves && tick && smp_reg.chamber <= stopThr) |=> !coolValves && !bypassValve)
      else $error("cycle not ended");
   startup_demand_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(started_reg) |-> bypassValve && alarmOut)
      else $error("startup demand missing");
   buzzer_off_a: assert property (@(posedge clk) disable iff (sys_rst)
      buzzerDisable |-> !buzzer)
      else $error("buzzer while disabled");
   supply_alarm_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg == ccc_pkg::PURGE && supExp) |=> supplyAlarm && coolValves)
      else $error("supply timeout missed");
   clamp_high_a: assert property (@(posedge clk) disable iff (sys_rst)
      (settings.chamberMax > `CCC_STORE_MAX) |-> (chMax == `CCC_STORE_MAX))
      else $error("chamber max not clamped high");
   clamp_low_a: assert property (@(posedge clk) disable iff (sys_rst)
      (settings.chamberMax < `CCC_STORE_MIN) |-> (chMax == `CCC_STORE_MIN))
      else $error("chamber max not clamped low");
   lid_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg == ccc_pkg::IDLE && tick && lidOpen && smp_reg.chamber > settings.lidMax
      && smp_reg.chamber <= chMax) |=> bypassValve)
      else $error("lid open demand missed");
   mute_silence_a: assert property (@(posedge clk) disable iff (sys_rst)
      (muteKey && alarmOut) |=> !buzzer)
      else $error("buzzer not muted");
   mute_resume_a: assert property (@(posedge clk) disable iff (sys_rst)
      ($fell(muteRun) && alarmOut && !buzzerDisable) |-> buzzer)
      else $error("buzzer not resumed");
   supply_timer_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg == ccc_pkg::PURGE) |-> (supRun || supExp))
      else $error("supply timer idle in purge");
endmodule

// File: ccc_consts.svh
`ifndef CCC_CONSTS_SVH
`define CCC_CONSTS_SVH
// Temperatures in signed tenths of a degree C
`define CCC_TEMP_W 12
`define CCC_STORE_MIN -12'sd1500
`define CCC_STORE_MAX -12'sd500
`define CCC_CLK_MHZ 50
`define CCC_MUTE_MIN 30
`define CCC_SUPPLY_MIN 5
`define CCC_CYC_PER_MIN (64'(`CCC_CLK_MHZ) * 64'd1000000 * 64'd60)
`define CCC_MUTE_CYC (`CCC_MUTE_MIN * `CCC_CYC_PER_MIN)
`define CCC_SUPPLY_CYC (`CCC_SUPPLY_MIN * `CCC_CYC_PER_MIN)
`define CCC_CNT_W 38
`define CCC_INLET_DEF -12'sd700
`define CCC_ONE 1
`endif

// File: ccc_pkg.sv
package ccc_pkg;
   typedef enum logic [2:0] {
      IDLE, PURGE, COOL, COILHOLD
   } ccc_state_type;
   typedef struct packed {
      logic signed [11:0] inletSet;
      logic signed [11:0] chamberMax;
      logic signed [11:0] coilMin;
      logic signed [11:0] coilBand;
      logic signed [11:0] chamberBand;
      logic signed [11:0] lidMax;
   } ccc_settings_type;
   typedef struct packed {
      logic signed [11:0] inlet;
      logic signed [11:0] coil;
      logic signed [11:0] chamber;
   } ccc_temps_type;
endpackage

// File: ccc_timer.sv
`include "ccc_consts.svh"
module ccc_timer #(
   parameter logic [`CCC_CNT_W-1:0] COUNT = `CCC_CNT_W'(`CCC_MUTE_CYC)
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic stop,
   output logic running,
   output logic expired
);
   logic [`CCC_CNT_W-1:0] cnt_reg, cnt_next;
   logic run_reg, run_next, exp_reg, exp_next;
   always_comb begin
      cnt_next = cnt_reg;
      run_next = run_reg;
      exp_next = 1'b0;
      if (stop) begin
         run_next = 1'b0;
      end else if (start) begin
         run_next = 1'b1;
         cnt_next = COUNT;
      end else if (run_reg) begin
         if (cnt_reg <= `CCC_CNT_W'(`CCC_ONE)) begin
            run_next = 1'b0;
            exp_next = 1'b1;
         end else begin
            cnt_next = cnt_reg - `CCC_CNT_W'(`CCC_ONE);
         end
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         exp_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         run_reg <= run_next;
         exp_reg <= exp_next;
      end
   end
   assign running = run_reg;
   assign expired = exp_reg;
endmodule

// File: ccc_chamber_model.sv
module ccc_chamber_model (
   input wire logic clk,
   input wire logic tick,
   input wire logic load,
   input wire logic stall,
   input wire logic freeze,
   input wire logic bypassValve,
   input wire logic coolValves,
   input wire ccc_pkg::ccc_temps_type loadTemps,
   output ccc_pkg::ccc_temps_type temps,
   output logic sampleValid
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Gas and chamber response
   assign sampleValid = !freeze;
   always_ff @(posedge clk) begin
      if (load) begin
         temps <= loadTemps;
      end else if (tick) begin
         if (bypassValve && !stall) begin
            temps.inlet <= temps.inlet - 12'sd50;
         end else if (temps.inlet < -12'sd200) begin
            temps.inlet <= temps.inlet + 12'sd20;
         end
         if (coolValves) begin
            temps.coil <= temps.coil - 12'sd40;
            temps.chamber <= temps.chamber - 12'sd10;
         end else begin
            temps.chamber <= temps.chamber + 12'sd2;
            if (temps.coil < -12'sd300) begin
               temps.coil <= temps.coil + 12'sd20;
            end
         end
      end
   end
endmodule

// File: testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, sys_rst, tick, load, stall, freeze, lidOpen, muteKey, buzzerDisable, otherAlarm;
   logic bypassValve, coolValves, alarmOut, buzzer, supplyAlarm, sampleValid;
   logic [2:0] phase;
   logic [1:0] tickCnt;
   ccc_pkg::ccc_temps_type temps, loadTemps;
   ccc_pkg::ccc_settings_type settings;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   // ==========================================
   // Design and far side
   ccc_cooling_control #(.MUTE_CYC(38'd100), .SUPPLY_CYC(38'd200)) i_ccc_cooling_control (
      .clk(clk), .sys_rst(sys_rst), .tick(tick), .sampleValid(sampleValid), .temps(temps),
      .settings(settings), .lidOpen(lidOpen), .muteKey(muteKey),
      .buzzerDisable(buzzerDisable), .otherAlarm(otherAlarm), .bypassValve(bypassValve),
      .coolValves(coolValves), .alarmOut(alarmOut), .buzzer(buzzer),
      .supplyAlarm(supplyAlarm), .phase(phase));
   ccc_chamber_model i_ccc_chamber_model (
      .clk(clk), .tick(tick), .load(load), .stall(stall), .freeze(freeze),
      .bypassValve(bypassValve),
      .coolValves(coolValves), .loadTemps(loadTemps), .temps(temps),
      .sampleValid(sampleValid));
   // ==========================================
   // Clock, tick and watchdog
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(negedge clk) begin
      tickCnt <= tickCnt + 2'h1;
      tick <= (tickCnt == 2'h3);
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   // ==========================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic waitPhase(input logic [2:0] p);
      int i;
      i = 0;
      while (phase !== p && i < 1000) begin
         @(negedge clk);
         i++;
      end
      check(16'(phase), 16'(p));
   endtask
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      loadTemps = '{inlet: -12'sd200, coil: -12'sd500, chamber: -12'sd780};
      load = 1'h1;
      sys_rst = 1'h1;
      cyc(12);
      check(16'({alarmOut, buzzer, bypassValve, coolValves}), 16'h000c);
      load = 1'h0;
      sys_rst = 1'h0;
      cyc(2);
      check(16'({alarmOut, bypassValve, phase}), 16'h0019);
   endtask
   task automatic t_purge;
      cyc(16);
      check(16'({bypassValve, coolValves, temps.inlet > -12'sd700}), 16'h0005);
      waitPhase(ccc_pkg::COOL);
      cyc(1);
      check(16'({bypassValve, coolValves}), 16'h0001);
   endtask
   task automatic t_coil;
      waitPhase(ccc_pkg::COILHOLD);
      cyc(1);
      check(16'({coolValves, temps.coil < -12'sd750}), 16'h0001);
      waitPhase(ccc_pkg::COOL);
      check(16'(temps.coil >= -12'sd550), 16'h0001);
      cyc(1);
      check(16'(coolValves), 16'h0001);
   endtask
   task automatic t_end(input logic expAlarm);
      waitPhase(ccc_pkg::IDLE);
      cyc(1);
      check(16'({coolValves, temps.chamber <= -12'sd900}), 16'h0001);
      check(16'(alarmOut), 16'(expAlarm));
   endtask
   task automatic t_lid;
      lidOpen = 1'h1;
      stall = 1'h1;
      buzzerDisable = 1'h1;
      muteKey = 1'h1;
      cyc(1);
      muteKey = 1'h0;
      waitPhase(ccc_pkg::PURGE);
      check(16'({bypassValve, supplyAlarm, temps.chamber < -12'sd800}), 16'h0005);
      waitPhase(ccc_pkg::COOL);
      cyc(1);
      check(16'({supplyAlarm, bypassValve}), 16'h0002);
      stall = 1'h0;
      lidOpen = 1'h0;
      buzzerDisable = 1'h0;
      t_end(1'h1);
   endtask
   task automatic t_mute;
      otherAlarm = 1'h1;
      cyc(2);
      check(16'(buzzer), 16'h0001);
      muteKey = 1'h1;
      cyc(1);
      muteKey = 1'h0;
      cyc(90);
      check(16'(buzzer), 16'h0000);
      cyc(20);
      check(16'(buzzer), 16'h0001);
      buzzerDisable = 1'h1;
      cyc(2);
      check(16'(buzzer), 16'h0000);
   endtask
   task automatic t_clamp;
      loadTemps = '{inlet: -12'sd200, coil: -12'sd500, chamber: -12'sd1800};
      load = 1'h1;
      cyc(1);
      load = 1'h0;
      cyc(1);
      settings.chamberMax = -12'sd2000;
      cyc(12);
      check(16'(phase), 16'(ccc_pkg::IDLE));
      settings.chamberMax = -12'sd100;
      loadTemps.chamber = -12'sd400;
      freeze = 1'h1;
      load = 1'h1;
      cyc(1);
      load = 1'h0;
      cyc(12);
      check(16'(phase), 16'(ccc_pkg::IDLE));
      freeze = 1'h0;
      cyc(12);
      check(16'(phase), 16'(ccc_pkg::PURGE));
   endtask
   // ==========================================
   // Main sequence
   initial begin
      tickCnt = 2'h0;
      tick = 1'h0;
      stall = 1'h0;
      freeze = 1'h0;
      lidOpen = 1'h0;
      muteKey = 1'h0;
      buzzerDisable = 1'h0;
      otherAlarm = 1'h0;
      settings = '{inletSet: -12'sd700, chamberMax: -12'sd800, coilMin: -12'sd750,
         coilBand: 12'sd200, chamberBand: 12'sd100, lidMax: -12'sd850};
      t_reset();
      t_purge();
      t_coil();
      t_end(1'h0);
      t_lid();
      t_mute();
      t_clamp();
      stop_test();
   end
endmodule
